// file: inc/dcds_defines.svh
// Register offsets, field positions and reset values of the datagram sequencer.
`ifndef DCDS_DEFINES_SVH
`define DCDS_DEFINES_SVH
`define DCDS_RAM_LAST 8'h7C
`define DCDS_CTRL_OFS 8'h80
`define DCDS_STAT_OFS 8'h84
`define DCDS_MOT0_OFS 8'h90
`define DCDS_MOT2_OFS 8'h98
`define DCDS_CTRL_SEND_BIT 8
`define DCDS_LAST_RST 2'h2
`define DCDS_NXM_BIT 5
`define DCDS_ODD_LSB 6
`define DCDS_DEF_WORDS 36
`define DCDS_DEF_FILL 6'h10
`define DCDS_DEF_LAYOUT {6'h2E, 6'h0A, 6'h0B, 6'h0C, 6'h0D, 6'h11, 6'h06, 6'h02, 6'h03, 6'h04, 6'h05, 6'h11}
`define DCDS_CODE_ZERO 5'h10
`define DCDS_CODE_ONE 5'h11
`define DCDS_CODE_DIR 5'h12
`define DCDS_CODE_STEP 5'h13
`endif

// file: inc/dcds_pkg.sv
// Types shared by the datagram sequencer design.
package dcds_pkg;
   // Sequencer states, Gray coded along idle, load, shift, done.
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_LOAD = 2'b01,
      ST_SHIFT = 2'b11,
      ST_DONE = 2'b10
   } dcds_state_e;
   // Control signals of one motor, coil A in the low bits.
   typedef struct packed {
      logic step;
      logic dir;
      logic fast_decay_b;
      logic phase_polarity_b;
      logic [5:0] dac_b;
      logic fast_decay_a;
      logic phase_polarity_a;
      logic [5:0] dac_a;
   } dcds_motor_s;
   // Latched address phase of a bus transfer.
   typedef struct packed {
      logic [7:0] addr;
      logic write;
   } dcds_bus_req_s;
endpackage

// file: verif/dcds_chain_model.sv
// Behavioural receiver model of the serial driver chain.
`timescale 1ns/1ps
module dcds_chain_model (
   input wire logic i_sck, // Link clock from the sequencer.
   input wire logic i_sdo, // Serial datagram bit.
   input wire logic i_sel_n, // Frame select, active low.
   output int o_frames, // Count of completed frames.
   output int o_len, // Bit count of the last frame.
   output logic [127:0] o_bits // Last frame, first bit in bit 0.
);
   int cnt = 0; // Bits taken in the open frame.
   logic [127:0] cur = '0; // Image of the open frame.
   initial o_frames = 0;
   // A new frame starts empty.
   always @(negedge i_sel_n) begin
      cnt = 0;
      cur = '0;
   end
   // Bits are taken on the rising link clock while selected.
   always @(posedge i_sck) begin
      if (i_sel_n === 1'b0 && cnt < 128) begin
         cur[cnt] = i_sdo;
         cnt++;
      end
   end
   // The chain latches its bits when the select is released.
   always @(posedge i_sel_n) begin
      if (cnt != 0) begin
         o_bits = cur;
         o_len = cnt;
         o_frames++;
      end
      cnt = 0;
   end
endmodule

// file: verif/tb_dcds_top.sv
// Self-checking testbench of the driver chain datagram sequencer.
`timescale 1ns/1ps
`include "dcds_defines.svh"
module tb_dcds_top;
   localparam logic [71:0] LAY = `DCDS_DEF_LAYOUT; // Default twelve-word pattern.
   logic clk, rst_n, hwrite, link_clk, hready, hresp, sck, sdo, sel_n;
   logic [1:0] htrans;
   logic [31:0] haddr, hwdata, hrdata, rd;
   logic [127:0] fbits, ebits;
   logic [5:0] img [64]; // Bench image of the configuration words.
   logic [17:0] mot [3]; // Bench image of the motor registers.
   int last = 2;
   int fail_count = 0;
   int cmp_count = 0;
   int frames, flen, off;
   int seed = 14402;
   dcds_top dut_u (.I_CLK_SYS(clk), .I_RESET_N(rst_n), .I_HSEL(1'h1), .I_HADDR(haddr),
      .I_HTRANS(htrans), .I_HWRITE(hwrite), .I_HSIZE(3'h2), .I_HWDATA(hwdata),
      .I_HREADY(hready), .O_HRDATA(hrdata), .O_HREADYOUT(hready), .O_HRESP(hresp),
      .I_LINK_CLK(link_clk), .O_LINK_SCK(sck), .O_LINK_SDO(sdo), .O_LINK_SEL_N(sel_n));
   dcds_chain_model chain_u (.i_sck(sck), .i_sdo(sdo), .i_sel_n(sel_n), .o_frames(frames),
      .o_len(flen), .o_bits(fbits));
   // System clock and an unrelated link clock.
   initial begin
      clk = 0;
      forever #50 clk = ~clk;
   end
   initial begin
      link_clk = 0;
      #37;
      forever #400 link_clk = ~link_clk;
   end
   // Counts one comparison and reports a mismatch.
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      cmp_count++;
      if (g !== e) begin
         fail_count++;
         $display("unexpected %s expected %h seen %h", n, e, g);
      end
   endtask
   // One single AHB-Lite transfer; read data lands in rd.
   task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
      haddr <= {24'h0, a};
      hwrite <= wr;
      htrans <= 2'h2;
      do @(posedge clk); while (hready !== 1'b1);
      htrans <= 2'h0;
      hwdata <= wd;
      do @(posedge clk); while (hready !== 1'b1);
      rd = hrdata;
      chk("response", 32'h0, {31'h0, hresp});
   endtask
   // Writes one RAM address from the image.
   task automatic ramw(input int a);
      bus(1'b1, 8'(4 * a), {20'h0, img[2 * a + 1], img[2 * a]});
   endtask
   // Power-on content of a configuration word.
   function automatic logic [5:0] dw(input int k);
      return (k < `DCDS_DEF_WORDS) ? LAY[6 * (k % 12) +: 6] : `DCDS_DEF_FILL;
   endfunction
   // Signal chosen by a select code for one motor.
   function automatic logic sig(input logic [17:0] m, input logic [4:0] c);
      if (c < 5'h10) return m[c[3:0]];
      case (c)
         5'h11: return 1'h1;
         5'h12: return m[16];
         5'h13: return m[17];
         default: return 1'h0;
      endcase
   endfunction
   // Expected frame bits from the images; returns the length.
   function automatic int expf(output logic [127:0] b);
      int n = 0;
      int s = 0;
      b = '0;
      while (n < 128) begin
         b[n] = sig((s < 3) ? mot[s] : 18'h0, img[n % 64][4:0]);
         n++;
         if (img[(n - 1) % 64][5]) begin
            if (s == last) return n;
            s++;
         end
      end
      return n;
   endfunction
   // Waits for frame n, then compares it and the idle status.
   task automatic frame_chk(input int n);
      int el;
      while (frames < n) @(posedge clk);
      el = expf(ebits);
      chk("frame length", el, flen);
      for (int k = 0; k < 4; k++) begin
         chk("frame bits", ebits[32 * k +: 32], fbits[32 * k +: 32]);
      end
      repeat (4) @(posedge clk);
      bus(1'b0, `DCDS_STAT_OFS, 32'h0);
      chk("status idle", 32'h0, rd & 32'h1F);
      chk("frame count", n, frames);
   endtask
   // Closing verdict.
   task automatic summarize();
      $display("compares %0d mismatches %0d", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   // Watchdog against a hung run.
   initial begin
      #2000000;
      fail_count++;
      summarize();
   end
   // Main sequence of tests.
   initial begin
      rst_n = 0;
      htrans = 0;
      haddr = 0;
      hwrite = 0;
      hwdata = 0;
      repeat (8) @(posedge clk);
      rst_n <= 1;
      @(posedge clk);
      chk("link idle", 32'h1, {29'h0, sck, sdo, sel_n});
      bus(1'b0, `DCDS_CTRL_OFS, 32'h0);
      chk("last index", {30'h0, `DCDS_LAST_RST}, rd & 32'h3);
      bus(1'b0, `DCDS_STAT_OFS, 32'h0);
      chk("status reset", 32'h0, rd & 32'h1F);
      bus(1'b0, 8'hA0, 32'h0);
      chk("unmapped", 32'h0, rd);
      for (int a = 0; a < 32; a++) begin
         bus(1'b0, 8'(4 * a), 32'h0);
         chk("ram default", {20'h0, dw(2 * a + 1), dw(2 * a)}, rd & 32'hFFF);
      end
      for (int k = 0; k < 64; k++) img[k] = dw(k);
      $display("test reset done");
      // Motor writes send datagrams on their own; the late ones wait.
      for (int m = 0; m < 3; m++) begin
         mot[m] = 18'($random(seed));
         bus(1'b1, 8'(`DCDS_MOT0_OFS + 4 * m), {14'h0, mot[m]});
      end
      frame_chk(2);
      $display("test default layout done");
      // Every select code once, in a rotated order.
      off = $unsigned($random(seed)) % 32;
      for (int k = 0; k < 64; k++) img[k] = {1'b0, 5'((k + off) % 32)};
      img[9][5] = 1'b1;
      img[20][5] = 1'b1;
      img[31][5] = 1'b1;
      for (int a = 0; a < 32; a++) ramw(a);
      bus(1'b1, `DCDS_CTRL_OFS, 32'h102);
      // Two codes trade places while the frame runs, well ahead of the word pointer.
      {img[28], img[29]} = {img[29], img[28]};
      ramw(14);
      img[62] = 6'($random(seed)) & 6'h1F;
      img[63] = 6'($random(seed)) & 6'h1F;
      ramw(31);
      bus(1'b0, `DCDS_RAM_LAST, 32'h0);
      chk("ram in frame", {20'h0, img[63], img[62]}, rd & 32'hFFF);
      frame_chk(3);
      $display("test all codes done");
      // No next-driver flag anywhere: the frame never ends.
      img[9][5] = 1'b0;
      img[20][5] = 1'b0;
      img[31][5] = 1'b0;
      ramw(4);
      ramw(10);
      ramw(15);
      bus(1'b1, `DCDS_CTRL_OFS, 32'h102);
      repeat (800) @(posedge clk);
      bus(1'b0, `DCDS_STAT_OFS, 32'h0);
      chk("endless state", 32'h3, rd & 32'h3);
      chk("endless select", 32'h0, {31'h0, sel_n});
      chk("endless count", 32'h3, frames);
      rst_n <= 0;
      repeat (2) @(posedge clk);
      rst_n <= 1;
      @(posedge clk);
      chk("select after reset", 32'h1, {31'h0, sel_n});
      bus(1'b0, 8'h24, 32'h0);
      chk("ram after reset", {20'h0, dw(19), dw(18)}, rd & 32'hFFF);
      $display("test endless frame done");
      summarize();
   end
endmodule

// file: verilog/dcds_top.sv
// Driver chain datagram sequencer with AHB-Lite register access and serial link.
`timescale 1ns/1ps
`include "dcds_defines.svh"

module dcds_top import dcds_pkg::*; #(
   parameter int NMOT = 3 // Number of driver slots in the chain.
) (
   input wire logic I_CLK_SYS, // System clock, 10 MHz.
   input wire logic I_RESET_N, // Asynchronous reset, active low.
   input wire logic I_HSEL, // Slave select.
   input wire logic [31:0] I_HADDR, // Byte address.
   input wire logic [1:0] I_HTRANS, // Transfer type.
   input wire logic I_HWRITE, // Write when high.
   input wire logic [2:0] I_HSIZE, // Transfer size, words only.
   input wire logic [31:0] I_HWDATA, // Write data.
   input wire logic I_HREADY, // Bus ready.
   output logic [31:0] O_HRDATA, // Read data.
   output logic O_HREADYOUT, // Slave ready.
   output logic O_HRESP, // Response, always OKAY.
   input wire logic I_LINK_CLK, // Link clock from outside.
   output logic O_LINK_SCK, // Gated link clock to the chain.
   output logic O_LINK_SDO, // Serial datagram bit.
   output logic O_LINK_SEL_N // Frame select, active low.
);

   dcds_state_e state_r; // Sequencer state.
   logic [5:0] cfg_r [0:63]; // Configuration words, even then odd per address.
   dcds_motor_s mot_r [0:NMOT-1]; // Live motor signals written by the host.
   dcds_motor_s snap_r [0:NMOT-1]; // Captured signals used while shifting.
   logic [1:0] last_r; // Last driver index.
   logic [1:0] slot_r; // Driver slot index.
   logic [5:0] wp_r; // Configuration word pointer.
   logic pend_r; // Datagram request waiting.
   dcds_bus_req_s req_r; // Latched address phase.
   logic dphase_r; // Data phase in progress.
   logic lk_s1, lk_s2, lk_s3; // Link clock synchroniser and edge history.
   logic lk_fall; // Falling edge of the link clock.
   logic wr_en; // Register write in this cycle.
   logic req_hit; // Write that asks for a datagram.
   logic [5:0] cur_word; // Word addressed by the pointer.
   logic cur_bit; // Bit selected for the current slot.

   // Picks one signal of a motor by its select code; unused codes give zero.
   function automatic logic sel_bit(input dcds_motor_s m, input logic [4:0] c);
      logic [17:0] v;
      v = m;
      case (c)
         `DCDS_CODE_ZERO: sel_bit = 1'b0;
         `DCDS_CODE_ONE: sel_bit = 1'b1;
         `DCDS_CODE_DIR: sel_bit = m.dir;
         `DCDS_CODE_STEP: sel_bit = m.step;
         default: sel_bit = (c < 5'h10) ? v[c[3:0]] : 1'b0;
      endcase
   endfunction

   // Reset content of one configuration word: default chain layout.
   function automatic logic [5:0] def_word(input int i);
      logic [71:0] lay;
      lay = `DCDS_DEF_LAYOUT;
      if (i < `DCDS_DEF_WORDS) begin
         def_word = lay[(i % 12) * 6 +: 6];
      end else begin
         def_word = `DCDS_DEF_FILL;
      end
   endfunction

   // Link clock passes two flops before any logic looks at it.
   always_ff @(posedge I_CLK_SYS or negedge I_RESET_N) begin
      if (!I_RESET_N) begin
         lk_s1 <= 1'b0;
         lk_s2 <= 1'b0;
         lk_s3 <= 1'b0;
      end else begin
         lk_s1 <= I_LINK_CLK;
         lk_s2 <= lk_s1;
         lk_s3 <= lk_s2;
      end
   end

   assign lk_fall = lk_s3 & ~lk_s2;
   assign wr_en = dphase_r & req_r.write;
   assign cur_word = cfg_r[wp_r];
   assign cur_bit = (slot_r < NMOT) ? sel_bit(snap_r[slot_r], cur_word[4:0]) : 1'b0;
   assign req_hit = wr_en & (((req_r.addr == `DCDS_CTRL_OFS) & I_HWDATA[`DCDS_CTRL_SEND_BIT])
      | ((req_r.addr >= `DCDS_MOT0_OFS) & (req_r.addr <= `DCDS_MOT2_OFS)));

   // Bus slave: one wait cycle, then write takes effect or read data stands.
   always_ff @(posedge I_CLK_SYS or negedge I_RESET_N) begin
      if (!I_RESET_N) begin
         req_r <= '0;
         dphase_r <= 1'b0;
         O_HREADYOUT <= 1'b1;
         O_HRESP <= 1'b0;
      end else begin
         if (O_HREADYOUT && I_HREADY && I_HSEL && I_HTRANS[1]) begin
            // Address phase accepted; stall one cycle.
            req_r.addr <= I_HADDR[7:0];
            req_r.write <= I_HWRITE;
            dphase_r <= 1'b1;
            O_HREADYOUT <= 1'b0;
         end else if (dphase_r) begin
            // Data phase ends here.
            dphase_r <= 1'b0;
            O_HREADYOUT <= 1'b1;
         end
      end
   end

   // Read data mux, loaded in the stall cycle of a read.
   always_ff @(posedge I_CLK_SYS or negedge I_RESET_N) begin
      if (!I_RESET_N) begin
         O_HRDATA <= 32'h0000_0000;
      end else if (dphase_r && !req_r.write) begin
         O_HRDATA <= 32'h0000_0000;
         if (req_r.addr <= `DCDS_RAM_LAST) begin
            // Two words per address, served at any time.
            O_HRDATA[11:0] <= {cfg_r[{req_r.addr[6:2], 1'b1}],
               cfg_r[{req_r.addr[6:2], 1'b0}]};
         end else if (req_r.addr == `DCDS_CTRL_OFS) begin
            O_HRDATA[1:0] <= last_r;
         end else if (req_r.addr == `DCDS_STAT_OFS) begin
            O_HRDATA[4:0] <= {slot_r, pend_r, state_r};
         end else if (req_r.addr >= `DCDS_MOT0_OFS && req_r.addr <= `DCDS_MOT2_OFS) begin
            O_HRDATA[17:0] <= mot_r[req_r.addr[3:2]];
         end
      end
   end

   // Configuration RAM: default layout at reset, host writes any time.
   always_ff @(posedge I_CLK_SYS or negedge I_RESET_N) begin
      if (!I_RESET_N) begin
         for (int i = 0; i < 64; i++) begin
            cfg_r[i] <= def_word(i);
         end
      end else if (wr_en && req_r.addr <= `DCDS_RAM_LAST) begin
         // Code changes on the fly are picked up by the next word read.
         cfg_r[{req_r.addr[6:2], 1'b0}] <= I_HWDATA[5:0];
         cfg_r[{req_r.addr[6:2], 1'b1}] <= I_HWDATA[`DCDS_ODD_LSB +: 6];
      end
   end

   // Control and motor registers; reset leaves every motor at rest.
   always_ff @(posedge I_CLK_SYS or negedge I_RESET_N) begin
      if (!I_RESET_N) begin
         last_r <= `DCDS_LAST_RST;
         for (int m = 0; m < NMOT; m++) begin
            mot_r[m] <= '0;
         end
      end else if (wr_en) begin
         if (req_r.addr == `DCDS_CTRL_OFS) begin
            last_r <= I_HWDATA[1:0];
         end else if (req_r.addr >= `DCDS_MOT0_OFS && req_r.addr <= `DCDS_MOT2_OFS) begin
            mot_r[req_r.addr[3:2]] <= I_HWDATA[17:0];
         end
      end
   end

   // Pending request: set by host writes, cleared when a datagram starts.
   always_ff @(posedge I_CLK_SYS or negedge I_RESET_N) begin
      if (!I_RESET_N) begin
         pend_r <= 1'b0;
      end else if (req_hit) begin
         pend_r <= 1'b1;
      end else if (state_r == ST_IDLE) begin
         pend_r <= 1'b0;
      end
   end

   // Snapshot of all motor signals taken as a datagram starts.
   always_ff @(posedge I_CLK_SYS or negedge I_RESET_N) begin
      if (!I_RESET_N) begin
         for (int m = 0; m < NMOT; m++) begin
            snap_r[m] <= '0;
         end
      end else if (state_r == ST_IDLE && pend_r) begin
         for (int m = 0; m < NMOT; m++) begin
            snap_r[m] <= mot_r[m];
         end
      end
   end

   // Sequencer: one word per falling link edge, slot advance and end of frame.
   always_ff @(posedge I_CLK_SYS or negedge I_RESET_N) begin
      if (!I_RESET_N) begin
         state_r <= ST_IDLE;
         slot_r <= 2'h0;
         wp_r <= 6'h00;
         O_LINK_SDO <= 1'b0;
      end else begin
         case (state_r)
            ST_IDLE: begin
               slot_r <= 2'h0;
               wp_r <= 6'h00;
               if (pend_r) begin
                  state_r <= ST_LOAD;
               end
            end
            ST_LOAD, ST_SHIFT: begin
               if (lk_fall) begin
                  O_LINK_SDO <= cur_bit;
                  wp_r <= wp_r + 6'h01;
                  state_r <= ST_SHIFT;
                  if (cur_word[`DCDS_NXM_BIT]) begin
                     if (slot_r == last_r) begin
                        state_r <= ST_DONE;
                        slot_r <= 2'h0;
                     end else begin
                        slot_r <= slot_r + 2'h1;
                     end
                  end
               end
            end
            ST_DONE: begin
               // Last bit was sampled on the rising edge; release next fall.
               if (lk_fall) begin
                  state_r <= ST_IDLE;
                  O_LINK_SDO <= 1'b0;
               end
            end
            default: state_r <= ST_IDLE;
         endcase
      end
   end

   // Frame select and gated clock follow the sequencer state.
   always_ff @(posedge I_CLK_SYS or negedge I_RESET_N) begin
      if (!I_RESET_N) begin
         O_LINK_SEL_N <= 1'b1;
         O_LINK_SCK <= 1'b0;
      end else begin
         O_LINK_SEL_N <= (state_r == ST_IDLE);
         O_LINK_SCK <= lk_s2 & (state_r == ST_SHIFT || state_r == ST_DONE);
      end
   end

   default clocking cb @(posedge I_CLK_SYS); endclocking
   default disable iff (!I_RESET_N);

   logic wfall; // Helper: word consumed this cycle.
   assign wfall = lk_fall && (state_r == ST_LOAD || state_r == ST_SHIFT);

   sequence bus_addr_s;
      O_HREADYOUT && I_HREADY && I_HSEL && I_HTRANS[1];
   endsequence
   sequence bus_data_s;
      !O_HREADYOUT ##1 O_HREADYOUT;
   endsequence

   bus_answer_a: assert property (bus_addr_s |=> bus_data_s)
      else $error("bus answer not in two cycles");
   start_zero_a: assert property (state_r == ST_IDLE && pend_r |=>
      state_r == ST_LOAD && slot_r == 2'h0 && wp_r == 6'h00)
      else $error("datagram did not start at slot and word zero");
   snap_take_a: assert property (state_r == ST_IDLE && pend_r |=>
      snap_r[0] == $past(mot_r[0]))
      else $error("snapshot not taken at start");
   word_order_a: assert property (wfall |=> wp_r == $past(wp_r) + 6'h01
      && O_LINK_SDO == $past(cur_bit))
      else $error("word pointer or bit out of order");
   slot_step_a: assert property (wfall && cur_word[5] && slot_r != last_r |=>
      slot_r == $past(slot_r) + 2'h1)
      else $error("slot did not advance");
   frame_end_a: assert property (wfall && cur_word[5] && slot_r == last_r |=>
      state_r == ST_DONE && slot_r == 2'h0)
      else $error("datagram did not end at last slot");
   no_flag_a: assert property (wfall && !cur_word[5] |=> state_r == ST_SHIFT)
      else $error("datagram ended without flag");
   // A request inside a datagram stays pending and never restarts it; one that lands
   // while the sequencer still waits for its first link edge simply leaves it in load.
   hold_req_a: assert property (req_hit && state_r != ST_IDLE |=> pend_r
      && (state_r != ST_LOAD || $past(state_r) == ST_LOAD))
      else $error("request lost or interrupted datagram");
   sel_frame_a: assert property (state_r == ST_SHIFT |=> !O_LINK_SEL_N)
      else $error("select released inside datagram");
   idle_slot_a: assert property (state_r == ST_DONE && lk_fall |=>
      state_r == ST_IDLE ##1 O_LINK_SEL_N && slot_r == 2'h0)
      else $error("sequencer did not return to idle");
   // The chain must see no clock edge while its select is released.
   sck_gate_a: assert property (O_LINK_SEL_N |-> !O_LINK_SCK)
      else $error("link clock toggled outside a frame");
   // Waiting for the first link edge consumes no configuration word.
   load_wait_a: assert property (state_r == ST_LOAD && !lk_fall |=>
      state_r == ST_LOAD && $stable(wp_r))
      else $error("word consumed before first link edge");
   // Without a pending request the sequencer stays idle.
   idle_rest_a: assert property (state_r == ST_IDLE && !pend_r |=> state_r == ST_IDLE)
      else $error("datagram started without a request");
endmodule
